// [core/adcx_device.sv]
/*
  Converter end: serial frame receiver, write-only extended-control
  registers and the capture buffer write control.
  Assumes link pins and mode pins are asynchronous to clk.
*/
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ps
module adcx_device (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Serial link
  adcx_if.device lk,
  // Mode pins
  input wire logic ext_mode_pin,
  input wire logic pwrdn_pin,
  // Capture stream
  input wire logic cap_valid,
  input wire logic [7:0] cap_data,
  input wire logic cap_restart,
  // Effective settings
  output logic [8:0] gain_code,
  output logic [8:0] fine_phase,
  output logic coarse_enable,
  output logic [3:0] coarse_adjust_magnitude,
  output logic low_freq_sample_clock,
  output logic [1:0] buffer_size_select,
  output logic auto_stop_write,
  output logic dual_port_output_enable,
  // Capture status and output ports
  output logic buffer_full_flag,
  output logic [7:0] port_a_data,
  output logic port_a_valid,
  output logic [7:0] port_b_data,
  output logic port_b_valid
);
  import adcx_pkg::*;

  logic [4:0] pin_in;
  logic [4:0] meta_r;
  logic [4:0] sync_r;
  logic sclk_d_r;
  logic [31:0] shift_r;
  logic [5:0] bit_cnt_r;
  logic [8:0] gain_r;
  logic [8:0] fine_r;
  logic ena_r;
  logic [3:0] mag_r;
  logic lowf_r;
  logic [1:0] bsz_r;
  logic astop_r;
  logic dual_r;
  logic [12:0] wr_cnt_r;
  logic ab_sel_r;

  // Every link and mode pin goes through two flops
  assign pin_in = {lk.sclk, lk.scs_n, lk.sdata, ext_mode_pin, pwrdn_pin};

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_r <= 5'h08;
      sync_r <= 5'h08;
      sclk_d_r <= 1'b0;
    end else begin
      meta_r <= pin_in;
      sync_r <= meta_r;
      sclk_d_r <= sync_r[4];
    end
  end

  wire sclk_s = sync_r[4];
  wire cs_n_s = sync_r[3];
  wire sdat_s = sync_r[2];
  wire ext_s = sync_r[1];
  wire pd_s = sync_r[0];

  // Frame receiver, sampled on the rising serial clock
  wire take_bit = sclk_s & ~sclk_d_r & ~cs_n_s;
  wire [31:0] shift_nxt = {shift_r[30:0], sdat_s};
  wire frame_done = take_bit && (bit_cnt_r == LAST_BIT);
  wire [5:0] bit_cnt_nxt = cs_n_s ? 6'h00 :
                           frame_done ? 6'h00 :
                           take_bit ? bit_cnt_r + 6'h01 : bit_cnt_r;
  wire [11:0] rx_hdr = shift_nxt[FRAME_BITS-1:HDR_LO];
  wire [3:0] rx_addr = shift_nxt[HDR_LO-1:ADDR_LO];
  wire [15:0] rx_data = shift_nxt[15:0];

  // No writes land outside extended mode or during power-down
  wire wr_ok = frame_done && (rx_hdr == FRAME_HDR) && ext_s && !pd_s;
  wire wr_gain = wr_ok && (rx_addr == ADDR_GAIN);
  wire wr_fine = wr_ok && (rx_addr == ADDR_FINE);
  wire wr_coarse = wr_ok && (rx_addr == ADDR_COARSE);
  wire wr_capt = wr_ok && (rx_addr == ADDR_CAPT);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      shift_r <= 32'h0000_0000;
      bit_cnt_r <= 6'h00;
    end else begin
      if (take_bit) begin
        shift_r <= shift_nxt;
      end
      bit_cnt_r <= bit_cnt_nxt;
    end
  end

  // Stored register contents; low fill bits are discarded
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      gain_r <= GAIN_RST;
      fine_r <= FINE_RST;
    end else begin
      if (wr_gain) begin
        gain_r <= rx_data[CODE_HI:CODE_LO];
      end
      if (wr_fine) begin
        fine_r <= rx_data[CODE_HI:CODE_LO];
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ena_r <= ENA_RST;
      mag_r <= MAG_RST;
      lowf_r <= LOWF_RST;
    end else if (wr_coarse) begin
      ena_r <= rx_data[ENA_BIT];
      mag_r <= rx_data[MAG_HI:MAG_LO];
      lowf_r <= rx_data[LOWF_BIT];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bsz_r <= BSZ_RST;
      astop_r <= ASTOP_RST;
      dual_r <= DUAL_RST;
    end else if (wr_capt) begin
      bsz_r <= rx_data[BSZ_HI:BSZ_LO];
      astop_r <= rx_data[ASTOP_BIT];
      dual_r <= rx_data[DUAL_BIT];
    end
  end

  // Settings take effect directly, no calibration step in between
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      gain_code <= GAIN_RST;
      fine_phase <= FINE_RST;
      coarse_enable <= ENA_RST;
      coarse_adjust_magnitude <= MAG_RST;
      low_freq_sample_clock <= LOWF_RST;
      buffer_size_select <= BSZ_RST;
      auto_stop_write <= ASTOP_RST;
      dual_port_output_enable <= DUAL_RST;
    end else if (ext_s) begin
      gain_code <= gain_r;
      fine_phase <= fine_r;
      coarse_enable <= ena_r;
      coarse_adjust_magnitude <= mag_r;
      low_freq_sample_clock <= lowf_r;
      buffer_size_select <= bsz_r;
      auto_stop_write <= astop_r;
      dual_port_output_enable <= dual_r;
    end else begin
      // Normal mode: stored values stay but are not applied
      gain_code <= GAIN_RST;
      fine_phase <= FINE_RST;
      coarse_enable <= ENA_RST;
      coarse_adjust_magnitude <= MAG_RST;
      low_freq_sample_clock <= LOWF_RST;
      buffer_size_select <= BSZ_RST;
      auto_stop_write <= ASTOP_RST;
      dual_port_output_enable <= DUAL_RST;
    end
  end

  // Capture buffer write control, one buffer for both ports
  wire [12:0] depth = (buffer_size_select == 2'h0) ? DEPTH_0 :
                      (buffer_size_select == 2'h1) ? DEPTH_1 :
                      (buffer_size_select == 2'h2) ? DEPTH_2 : DEPTH_3;
  wire stop_wr = auto_stop_write && buffer_full_flag;
  wire cap_wr = cap_valid && !stop_wr;
  wire last_slot = (wr_cnt_r + 13'h0001) >= depth;
  wire fill_evt = cap_wr && last_slot && auto_stop_write;
  wire [12:0] wr_cnt_nxt = cap_restart ? 13'h0000 :
                           !cap_wr ? wr_cnt_r :
                           last_slot ? 13'h0000 : wr_cnt_r + 13'h0001;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_cnt_r <= 13'h0000;
      buffer_full_flag <= 1'b0;
    end else begin
      wr_cnt_r <= wr_cnt_nxt;
      // A fill in the restart cycle still raises the flag
      buffer_full_flag <= fill_evt | (buffer_full_flag & ~cap_restart);
    end
  end

  // Dual-port mode alternates samples, else port A carries all
  wire to_b = dual_port_output_enable && ab_sel_r;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ab_sel_r <= 1'b0;
      port_a_data <= 8'h00;
      port_a_valid <= 1'b0;
      port_b_data <= 8'h00;
      port_b_valid <= 1'b0;
    end else begin
      if (cap_restart || !dual_port_output_enable) begin
        ab_sel_r <= 1'b0;
      end else if (cap_wr) begin
        ab_sel_r <= ~ab_sel_r;
      end
      port_a_valid <= cap_wr && !to_b;
      port_b_valid <= cap_wr && to_b;
      if (cap_wr && !to_b) begin
        port_a_data <= cap_data;
      end
      if (cap_wr && to_b) begin
        port_b_data <= cap_data;
      end
    end
  end
endmodule : adcx_device

// [core/adcx_pkg.sv]
/*
  Shared constants for both ends of the converter's extended-control serial link:
  frame layout, register addresses, field positions, reset values and timing.
  Assumes a 20 MHz system clock on both ends.
*/
// Overview of operation
// - Gain code is 9 bits, 15:7
// - Gain code 0/0x100/0x1ff: low/nominal/high span
// - Host keeps gain within recommended bounds; here any 9-bit code is sent unchecked
// - Gain applies at once; resets to nominal
// - Fine phase code bits 15:7, resets zero
// - Host fills gain/fine bits 6:0 with ones
// - Phase enable resets zero; host sets trim-disable
// - Coarse magnitude bits 14:11, resets zero
// - Bit 10 low-frequency clock option, resets zero
// - Host fills coarse bits 9:0 with ones
// - Buffer size bits 15:14, upper resets one
// - Write-only, effective in extended mode only
// - Contents kept unchanged in power-down
package adcx_pkg;
  localparam int FRAME_BITS = 32;
  localparam logic [5:0] LAST_BIT = 6'h1f;
  localparam logic [11:0] FRAME_HDR = 12'h001;
  localparam int HDR_LO = 20;
  localparam int ADDR_LO = 16;
  localparam logic [3:0] ADDR_CFG = 4'h1;
  localparam logic [3:0] ADDR_GAIN = 4'h3;
  localparam logic [3:0] ADDR_FINE = 4'hd;
  localparam logic [3:0] ADDR_COARSE = 4'he;
  localparam logic [3:0] ADDR_CAPT = 4'hf;
  localparam int CODE_HI = 15;
  localparam int CODE_LO = 7;
  localparam int ENA_BIT = 15;
  localparam int MAG_HI = 14;
  localparam int MAG_LO = 11;
  localparam int LOWF_BIT = 10;
  localparam int BSZ_HI = 15;
  localparam int BSZ_LO = 14;
  localparam int ASTOP_BIT = 13;
  localparam int DUAL_BIT = 12;
  localparam logic [6:0] FILL_CODE = 7'h7f;
  localparam logic [9:0] FILL_COARSE = 10'h3ff;
  localparam logic [10:0] FILL_CAPT = 11'h7ff;
  localparam logic [15:0] CFG_TRIM_WORD = 16'hbeff;
  localparam logic [8:0] GAIN_RST = 9'h100;
  localparam logic [8:0] FINE_RST = 9'h000;
  localparam logic ENA_RST = 1'b0;
  localparam logic [3:0] MAG_RST = 4'h0;
  localparam logic LOWF_RST = 1'b0;
  localparam logic [1:0] BSZ_RST = 2'h2;
  localparam logic ASTOP_RST = 1'b0;
  localparam logic DUAL_RST = 1'b0;
  localparam logic [12:0] DEPTH_0 = 13'h0200;
  localparam logic [12:0] DEPTH_1 = 13'h0400;
  localparam logic [12:0] DEPTH_2 = 13'h0800;
  localparam logic [12:0] DEPTH_3 = 13'h1000;
  localparam int CLK_PERIOD_NS = 50;
  localparam int SCLK_PERIOD_NS = 400;
  localparam logic [3:0] SCLK_HALF_CYC = 4'(SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS));
  localparam logic [2:0] HREG_GAIN = 3'h0;
  localparam logic [2:0] HREG_FINE = 3'h1;
  localparam logic [2:0] HREG_COARSE = 3'h2;
  localparam logic [2:0] HREG_CAPT = 3'h3;
  localparam logic [2:0] HREG_STAT = 3'h4;
  localparam int HC_ENA = 5;
  localparam int HC_MAG_LO = 1;
  localparam int PEND_CFG = 0;
  localparam int PEND_GAIN = 1;
  localparam int PEND_FINE = 2;
  localparam int PEND_COARSE = 3;
  localparam int PEND_CAPT = 4;
endpackage : adcx_pkg

// [core/adcx_if.sv]
/*
  Serial control link between host and converter.
  Assumes the host makes the serial clock; all wires are one-way.
*/
`timescale 1ns/1ps
interface adcx_if;
  logic sclk;
  logic scs_n;
  logic sdata;
  modport host (output sclk, output scs_n, output sdata);
  modport device (input sclk, input scs_n, input sdata);
endinterface : adcx_if

// [core/adcx_host.sv]
/*
  Host end: software register port, write queue and serial frame sender.
  Assumes software strobes are synchronous to clk; host makes the serial clock.
*/
`timescale 1ns/1ps
module adcx_host (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Software port
  input wire logic [2:0] sw_addr,
  input wire logic [15:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  output logic [15:0] sw_rdata,
  // Serial link
  adcx_if.host lk
);
  import adcx_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_GAP} adcx_state_t;

  adcx_state_t state_r;
  logic [8:0] gain_r;
  logic [8:0] fine_r;
  logic [5:0] coarse_r;
  logic [3:0] capt_r;
  logic [4:0] pend_r;
  logic [31:0] frame_r;
  logic [3:0] div_r;
  logic [5:0] bit_r;
  logic sclk_r;
  logic scs_n_r;

  assign lk.sclk = sclk_r;
  assign lk.scs_n = scs_n_r;
  assign lk.sdata = frame_r[31];

  // Frame words; unused low bits sent as ones, except capture frame bit 11 sent as zero
  wire [31:0] w_cfg = {FRAME_HDR, ADDR_CFG, CFG_TRIM_WORD};
  wire [31:0] w_gain = {FRAME_HDR, ADDR_GAIN, gain_r, FILL_CODE};
  wire [31:0] w_fine = {FRAME_HDR, ADDR_FINE, fine_r, FILL_CODE};
  wire [31:0] w_coarse = {FRAME_HDR, ADDR_COARSE, coarse_r, FILL_COARSE};
  wire [31:0] w_capt = {FRAME_HDR, ADDR_CAPT, capt_r, 1'b0, FILL_CAPT};

  // Lowest pending first, so the trim-disable frame leads
  wire [31:0] w_sel = pend_r[PEND_CFG] ? w_cfg :
                      pend_r[PEND_GAIN] ? w_gain :
                      pend_r[PEND_FINE] ? w_fine :
                      pend_r[PEND_COARSE] ? w_coarse : w_capt;
  wire [4:0] pend_pick = pend_r & ~(pend_r - 5'h01);
  wire start = (state_r == ST_IDLE) && (pend_r != 5'h00);
  wire [4:0] pend_clr = start ? pend_pick : 5'h00;

  wire wr_gain = sw_wr && (sw_addr == HREG_GAIN);
  wire wr_fine = sw_wr && (sw_addr == HREG_FINE);
  wire wr_coarse = sw_wr && (sw_addr == HREG_COARSE);
  wire wr_capt = sw_wr && (sw_addr == HREG_CAPT);
  wire coarse_ena = wr_coarse && sw_wdata[HC_ENA];
  wire [4:0] pend_set = {wr_capt, wr_coarse, wr_fine, wr_gain, coarse_ena};

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      gain_r <= GAIN_RST;
      fine_r <= FINE_RST;
      coarse_r <= {ENA_RST, MAG_RST, LOWF_RST};
      capt_r <= {BSZ_RST, ASTOP_RST, DUAL_RST};
      pend_r <= 5'h00;
    end else begin
      if (wr_gain) begin
        gain_r <= sw_wdata[8:0];
      end
      if (wr_fine) begin
        fine_r <= sw_wdata[8:0];
      end
      if (wr_coarse) begin
        coarse_r <= sw_wdata[5:0];
      end
      if (wr_capt) begin
        capt_r <= sw_wdata[3:0];
      end
      pend_r <= (pend_r & ~pend_clr) | pend_set;
    end
  end

  wire busy = (state_r != ST_IDLE);
  wire [15:0] rd_mux = (sw_addr == HREG_GAIN) ? {7'h00, gain_r} :
                       (sw_addr == HREG_FINE) ? {7'h00, fine_r} :
                       (sw_addr == HREG_COARSE) ? {10'h000, coarse_r} :
                       (sw_addr == HREG_CAPT) ? {12'h000, capt_r} :
                       (sw_addr == HREG_STAT) ? {10'h000, busy, pend_r} : 16'h0000;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sw_rdata <= 16'h0000;
    end else begin
      sw_rdata <= sw_rd ? rd_mux : 16'h0000;
    end
  end

  // Serial clock divider and bit sequencer
  wire half_up = (div_r == SCLK_HALF_CYC - 4'h1);
  wire last_fall = half_up && sclk_r && (bit_r == LAST_BIT);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= ST_IDLE;
      frame_r <= 32'h0000_0000;
      div_r <= 4'h0;
      bit_r <= 6'h00;
      sclk_r <= 1'b0;
      scs_n_r <= 1'b1;
    end else begin
      case (state_r)
        ST_IDLE: begin
          div_r <= 4'h0;
          bit_r <= 6'h00;
          if (start) begin
            frame_r <= w_sel;
            scs_n_r <= 1'b0;
            state_r <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          div_r <= half_up ? 4'h0 : div_r + 4'h1;
          if (half_up) begin
            sclk_r <= ~sclk_r;
            if (sclk_r) begin
              frame_r <= {frame_r[30:0], 1'b1};
              bit_r <= bit_r + 6'h01;
            end
          end
          if (last_fall) begin
            scs_n_r <= 1'b1;
            state_r <= ST_GAP;
          end
        end
        ST_GAP: begin
          // Select stays high a half period between frames
          div_r <= half_up ? 4'h0 : div_r + 4'h1;
          if (half_up) begin
            state_r <= ST_IDLE;
          end
        end
        default: begin
          state_r <= ST_IDLE;
          scs_n_r <= 1'b1;
          sclk_r <= 1'b0;
        end
      endcase
    end
  end
endmodule : adcx_host

// [test/adcx_props.sv]
/*
  Checker for the serial link and the device settings that it drives.
  Assumes the bench wires it beside the link interface.
*/
`timescale 1ns/1ps
module adcx_props (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Link
  input wire logic sclk,
  input wire logic scs_n,
  input wire logic sdata,
  // Device side
  input wire logic ext_mode_pin,
  input wire logic pwrdn_pin,
  input wire logic cap_valid,
  input wire logic [8:0] gain_code,
  input wire logic [8:0] fine_phase,
  input wire logic auto_stop_write,
  input wire logic dual_port_output_enable,
  input wire logic buffer_full_flag,
  input wire logic port_a_valid,
  input wire logic port_b_valid
);
  import adcx_pkg::*;
  logic sclk_d_r;
  logic [5:0] cnt_r;
  logic [31:0] sh_r;
  logic [31:0] prev_r;
  wire rise = sclk && !sclk_d_r && !scs_n;
  wire fr_end = scs_n && (cnt_r == 6'h20);
  wire [3:0] fr_adr = sh_r[19:16];
  wire live = ext_mode_pin && !pwrdn_pin;
  wire taken = cap_valid && !(auto_stop_write && buffer_full_flag);

  // Frame rebuilt from the wire; the previous one is kept for ordering
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sclk_d_r <= 1'b0;
      cnt_r <= 6'h00;
      sh_r <= 32'h0;
      prev_r <= 32'h0;
    end else begin
      sclk_d_r <= sclk;
      cnt_r <= scs_n ? 6'h00 : cnt_r + 6'(rise);
      if (rise) begin
        sh_r <= {sh_r[30:0], sdata};
      end
      if (fr_end) begin
        prev_r <= sh_r;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  chk_frame_whole: assert property (
    $rose(scs_n) |-> cnt_r == 6'h20 && sh_r[31:20] == FRAME_HDR)
    else $error("frame cut short or bad header");
  chk_code_fill: assert property (
    fr_end && (fr_adr == ADDR_GAIN || fr_adr == ADDR_FINE) |-> sh_r[6:0] == FILL_CODE)
    else $error("code frame low bits not ones");
  chk_coarse_fill: assert property (
    fr_end && fr_adr == ADDR_COARSE |-> sh_r[9:0] == FILL_COARSE)
    else $error("coarse frame low bits not ones");
  chk_trim_first: assert property (
    fr_end && fr_adr == ADDR_COARSE && sh_r[ENA_BIT]
      |-> prev_r[19:16] == ADDR_CFG && prev_r[13])
    else $error("phase enable sent without trim disable");
  chk_gain_apply: assert property (
    fr_end && fr_adr == ADDR_GAIN && live |-> ##[0:8] gain_code == sh_r[15:7])
    else $error("gain code not applied");
  chk_fine_apply: assert property (
    fr_end && fr_adr == ADDR_FINE && live |-> ##[0:8] fine_phase == sh_r[15:7])
    else $error("fine phase not applied");
  chk_normal_nom: assert property (
    (!ext_mode_pin) [*4] |-> gain_code == GAIN_RST && fine_phase == FINE_RST)
    else $error("settings active in normal mode");
  chk_pwrdn_keep: assert property (
    (pwrdn_pin && ext_mode_pin) [*4] |=> $stable(gain_code) && $stable(fine_phase))
    else $error("settings changed in power-down");
  chk_full_stop: assert property (
    cap_valid && auto_stop_write && buffer_full_flag |=> !port_a_valid && !port_b_valid)
    else $error("write past full buffer");
  chk_one_port: assert property (
    taken && !dual_port_output_enable |=> port_a_valid && !port_b_valid)
    else $error("single-port sample misplaced");

  cov_gain: cover property (fr_end && fr_adr == ADDR_GAIN && live);
  cov_full: cover property ($rose(buffer_full_flag));
  cov_dual: cover property (taken && dual_port_output_enable);
endmodule : adcx_props

// [test/adcx_bench.sv]
/*
  Bench joining host and device over the link; drives software port,
  mode pins and capture stream. Assumes the package and interface files.
*/
`timescale 1ns/1ps
module adcx_bench;
  import adcx_pkg::*;
  typedef struct packed {logic [2:0] a; logic [15:0] d; logic [27:0] e;} adcx_row_t;
  logic clk;
  logic arst_n;
  logic [2:0] sw_addr;
  logic [15:0] sw_wdata;
  logic sw_wr;
  logic sw_rd;
  logic [15:0] sw_rdata;
  logic ext_mode_pin;
  logic pwrdn_pin;
  logic cap_valid;
  logic [7:0] cap_data;
  logic cap_restart;
  logic [8:0] gain_code;
  logic [8:0] fine_phase;
  logic coarse_enable;
  logic [3:0] coarse_adjust_magnitude;
  logic low_freq_sample_clock;
  logic [1:0] buffer_size_select;
  logic auto_stop_write;
  logic dual_port_output_enable;
  logic buffer_full_flag;
  logic [7:0] port_a_data;
  logic port_a_valid;
  logic [7:0] port_b_data;
  logic port_b_valid;
  logic [15:0] rd_v;
  int mismatches;
  int n_tests;
  int na;
  int nb;
  localparam logic [27:0] SET_RST = {GAIN_RST, FINE_RST, ENA_RST, MAG_RST, LOWF_RST,
    BSZ_RST, ASTOP_RST, DUAL_RST};
  wire [27:0] sets = {gain_code, fine_phase, coarse_enable, coarse_adjust_magnitude,
    low_freq_sample_clock, buffer_size_select, auto_stop_write, dual_port_output_enable};
  // Host register, value, then all settings expected after the frame
  adcx_row_t rows [9] = '{
    '{3'h0, 16'h0000, 28'h0000008}, '{3'h0, 16'h01ff, 28'hff80008},
    '{3'h1, 16'h01ff, 28'hffffc08}, '{3'h2, 16'h003f, 28'hffffff8},
    '{3'h3, 16'h000f, 28'hfffffff}, '{3'h2, 16'h000a, 28'hffffcaf},
    '{3'h3, 16'h0000, 28'hffffca0}, '{3'h0, 16'h00c0, 28'h607fca0},
    '{3'h1, 16'h0000, 28'h60000a0}};

  adcx_if lk();
  adcx_host adcx_host_i (.clk(clk), .arst_n(arst_n), .sw_addr(sw_addr),
    .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .lk(lk));
  adcx_device adcx_device_i (.clk(clk), .arst_n(arst_n), .lk(lk),
    .ext_mode_pin(ext_mode_pin), .pwrdn_pin(pwrdn_pin), .cap_valid(cap_valid),
    .cap_data(cap_data), .cap_restart(cap_restart), .gain_code(gain_code),
    .fine_phase(fine_phase), .coarse_enable(coarse_enable),
    .coarse_adjust_magnitude(coarse_adjust_magnitude),
    .low_freq_sample_clock(low_freq_sample_clock), .buffer_size_select(buffer_size_select),
    .auto_stop_write(auto_stop_write), .dual_port_output_enable(dual_port_output_enable),
    .buffer_full_flag(buffer_full_flag), .port_a_data(port_a_data),
    .port_a_valid(port_a_valid), .port_b_data(port_b_data), .port_b_valid(port_b_valid));
  adcx_props adcx_props_i (.clk(clk), .arst_n(arst_n), .sclk(lk.sclk), .scs_n(lk.scs_n),
    .sdata(lk.sdata), .ext_mode_pin(ext_mode_pin), .pwrdn_pin(pwrdn_pin),
    .cap_valid(cap_valid), .gain_code(gain_code), .fine_phase(fine_phase),
    .auto_stop_write(auto_stop_write), .dual_port_output_enable(dual_port_output_enable),
    .buffer_full_flag(buffer_full_flag), .port_a_valid(port_a_valid),
    .port_b_valid(port_b_valid));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  always @(posedge clk) begin
    na = na + int'(port_a_valid);
    nb = nb + int'(port_b_valid);
  end

  task automatic chk(input string nm, input logic [27:0] e, input logic [27:0] g);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic sw_write(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge clk);
    sw_wr <= 1'b0;
  endtask : sw_write

  task automatic sw_read(input logic [2:0] a, output logic [15:0] d);
    @(posedge clk);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge clk);
    sw_rd <= 1'b0;
    @(negedge clk);
    d = sw_rdata;
  endtask : sw_read

  // Polls busy and pending; bounded so a stuck sender cannot hang the run
  task automatic wait_link();
    int k;
    k = 0;
    do begin
      sw_read(HREG_STAT, rd_v);
      k++;
    end while (rd_v[5:0] !== 6'h00 && k < 2000);
    chk("link_idle", 28'h0, {22'h0, rd_v[5:0]});
    repeat (10) @(posedge clk);
  endtask : wait_link

  task automatic push(input int n);
    @(negedge clk);
    na = 0;
    nb = 0;
    @(posedge clk);
    cap_restart <= 1'b1;
    @(posedge clk);
    cap_restart <= 1'b0;
    for (int i = 0; i < n; i++) begin
      cap_valid <= 1'b1;
      cap_data <= 8'(i);
      @(posedge clk);
    end
    cap_valid <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : push

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : stop_test

  // About 16 frames of 260 clk plus capture traffic; four times that margin
  initial begin
    #(30000 * 50);
    mismatches++;
    $display("mismatch watchdog expected done seen timeout");
    stop_test();
  end

  initial begin
    arst_n = 1'b0;
    sw_addr = 3'h0;
    sw_wdata = 16'h0;
    sw_wr = 1'b0;
    sw_rd = 1'b0;
    ext_mode_pin = 1'b1;
    pwrdn_pin = 1'b0;
    cap_valid = 1'b0;
    cap_data = 8'h0;
    cap_restart = 1'b0;
    mismatches = 0;
    n_tests = 0;
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    chk("reset", SET_RST, sets);
    sw_read(3'h7, rd_v);
    chk("unmapped", 28'h0, {12'h0, rd_v});
    $display("test reset done");
    for (int i = 0; i < 9; i++) begin
      sw_write(rows[i].a, rows[i].d);
      wait_link();
      chk("settings", rows[i].e, sets);
    end
    $display("test table done");
    ext_mode_pin <= 1'b0;
    sw_write(HREG_GAIN, 16'h0055);
    wait_link();
    chk("normal", SET_RST, sets);
    ext_mode_pin <= 1'b1;
    repeat (6) @(posedge clk);
    chk("retained", 28'h60000a0, sets);
    pwrdn_pin <= 1'b1;
    repeat (6) @(posedge clk);
    sw_write(HREG_GAIN, 16'h01aa);
    wait_link();
    chk("pwrdn", 28'h60000a0, sets);
    pwrdn_pin <= 1'b0;
    repeat (6) @(posedge clk);
    $display("test modes done");
    sw_write(HREG_CAPT, 16'h0002);
    wait_link();
    push(513);
    chk("stop_count", 28'h200, 28'(na + nb));
    chk("stop_full", 28'h1, {27'h0, buffer_full_flag});
    sw_write(HREG_CAPT, 16'h0000);
    wait_link();
    push(600);
    chk("wrap_count", 28'h258, 28'(na));
    chk("wrap_full", 28'h0, {27'h0, buffer_full_flag});
    // Second size code, auto-stop on, so the depth shows in the count
    sw_write(HREG_CAPT, 16'h0006);
    wait_link();
    push(1025);
    chk("size1_count", 28'h400, 28'(na + nb));
    chk("size1_full", 28'h1, {27'h0, buffer_full_flag});
    sw_write(HREG_CAPT, 16'h0001);
    wait_link();
    push(4);
    chk("dual_count", 28'h2, 28'(nb));
    chk("dual_data", 28'h0203, {12'h0, port_a_data, port_b_data});
    $display("test capture done");
    arst_n <= 1'b0;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    chk("rereset", SET_RST, sets);
    $display("test rereset done");
    stop_test();
  end
endmodule : adcx_bench
